// ==== core/dds_ctrl_pkg.sv ====
// Shared widths, word fields and control bit positions of the synthesizer front end.
package dds_ctrl_pkg;

	// ==========================================================
	// Datapath widths
	localparam int ACC_W     = 28;
	localparam int PHASE_W   = 12;
	localparam int WORD_W    = 16;
	localparam int CNT_W     = 5;
	localparam int HALF_W    = 14;
	localparam int SYNC_W    = 5;

	// ==========================================================
	// Serial word layout: two address bits above the payload
	localparam int ADDR_HI   = 15;
	localparam int ADDR_LO   = 14;
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_FREQ_A = 2'h1;
	localparam logic [1:0] ADDR_FREQ_B = 2'h2;
	localparam logic [1:0] ADDR_PHASE  = 2'h3;
	localparam int PHASE_SEL_POS = 13;

	// ==========================================================
	// Control word bit positions
	localparam int CTL_FREQ_WORD_SELECT_BIT_POS   = 0;
	localparam int CTL_PSEL_POS   = 1;
	localparam int CTL_PINSEL_POS = 2;
	localparam int CTL_SLEEP_POS  = 3;
	localparam int CTL_OEN_POS    = 4;
	localparam int CTL_SRC_POS    = 5;
	localparam int CTL_HALF_POS   = 6;
	localparam int CTL_W          = 7;
	localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;

	// ==========================================================
	// Synchroniser input order
	localparam int SYN_FREQ_WORD_SELECT_BIT  = 0;
	localparam int SYN_PSEL  = 1;
	localparam int SYN_RST   = 2;
	localparam int SYN_SLEEP = 3;
	localparam int SYN_COMP  = 4;

endpackage

// ==== core/dds_bit_sync.sv ====
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/10ps
`default_nettype none
module dds_bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== core/dds_serial_rx.sv ====
// Serial word receiver running on the link clock.
`timescale 1ns/10ps
`default_nettype none
module dds_serial_rx (
	input  wire logic                          serial_clk,
	input  wire logic                          frame_sync_n,
	input  wire logic                          serial_data_in,
	output logic [dds_ctrl_pkg::WORD_W-1:0]    word_q,
	output logic                               word_done_q
);
	logic [dds_ctrl_pkg::CNT_W-1:0] cnt_q;

	// Bits shift in on the falling edge; the frame's end clears the count.
	always_ff @(negedge serial_clk or posedge frame_sync_n) begin
		if (frame_sync_n) begin
			cnt_q       <= '0;
			word_done_q <= 1'b0;
		end else if (!word_done_q) begin
			cnt_q <= cnt_q + 1'b1;
			if (cnt_q == dds_ctrl_pkg::CNT_W'(dds_ctrl_pkg::WORD_W - 1))
				word_done_q <= 1'b1;
		end
	end

	// Shift register; stable from the sixteenth bit to the next frame.
	always_ff @(negedge serial_clk) begin // RULE_02
		if (!frame_sync_n && !word_done_q) // RULE_03
			word_q <= {word_q[dds_ctrl_pkg::WORD_W-2:0], serial_data_in};
	end
endmodule
`default_nettype wire

// ==== core/dds_pin_ctrl.sv ====
// Pin control front end of a direct digital synthesizer.
// Function
// RULE_01: Serial transfers are words of exactly sixteen bits.
// RULE_02: One serial data bit is sampled on each falling serial clock edge.
// RULE_03: Frame sync low starts loading a new word.
// RULE_04: Synthesis runs only on the master clock; frequency is a fraction of it.
// RULE_05: Accumulator adds one of two stored frequency words chosen by select.
// RULE_06: Frequency word chosen by pin or control bit; pin held fixed otherwise.
// RULE_07: One of two stored phase offsets is added to accumulator output.
// RULE_08: Phase offset chosen by pin or control bit; pin held fixed otherwise.
// RULE_09: Reset input high clears accumulator and phase output to zero.
// RULE_10: Reset input leaves all host written words unchanged.
// RULE_11: Sleep input high powers down the DAC like the power-down bit.
// RULE_12: Sign output is driven only when the output enable bit is one.
// RULE_13: Source bit routes comparator or oscillator MSB onto the sign output.
// RULE_14: Enable and source both set connect comparator input to the output.
// RULE_15: Accumulator is 28 bits, adds the word every clock, wraps.
// RULE_16: Two 12-bit phase offsets are added to the accumulator top bits.
// RULE_17: Oscillator MSB routing presents accumulator bit 27.
`timescale 1ns/10ps
`default_nettype none
module dds_pin_ctrl #(
	parameter int ACC_W   = dds_ctrl_pkg::ACC_W,
	parameter int PHASE_W = dds_ctrl_pkg::PHASE_W
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               serial_clk,
	input  wire logic               frame_sync_n,
	input  wire logic               serial_data_in,
	input  wire logic               freq_word_select_pin,
	input  wire logic               phase_word_select_pin,
	input  wire logic               dds_reset,
	input  wire logic               dac_sleep_pin,
	input  wire logic               comparator_input,
	output logic      [PHASE_W-1:0] phase_word_q,
	output logic      [ACC_W-1:0]   accum_q,
	output logic                    dac_powered_down,
	output logic                    comparator_connect,
	output logic                    sign_out_q,
	output logic                    sign_out_oe_n
);
	// ==========================================================
	// Declarations
	logic [dds_ctrl_pkg::WORD_W-1:0] rx_word;
	logic                            rx_done;
	logic                            done_s1_q;
	logic                            done_s2_q;
	logic                            done_prev_q;
	logic                            load;
	logic [dds_ctrl_pkg::SYNC_W-1:0] pins_raw;
	logic [dds_ctrl_pkg::SYNC_W-1:0] pins_s;
	logic [dds_ctrl_pkg::CTL_W-1:0]  ctl_q;
	logic [ACC_W-1:0]                freq_word_a;
	logic [ACC_W-1:0]                freq_word_b;
	logic [PHASE_W-1:0]              phase_offset_a;
	logic [PHASE_W-1:0]              phase_offset_b;
	logic                            freq_word_select_bit;
	logic                            phase_word_select_bit;
	logic                            pin_select_mode;
	logic                            dac_powerdown_bit;
	logic                            logic_out_enable_bit;
	logic                            logic_out_source_bit;
	logic                            freq_half_msb_bit;
	logic                            freq_pick;
	logic                            phase_pick;
	logic [ACC_W-1:0]                freq_sel;
	logic [PHASE_W-1:0]              phase_sel;
	logic                            reset_s;
	logic                            sleep_s;
	logic                            comp_s;

	// Merges a 14-bit payload into one half of a 28-bit frequency word.
	function automatic logic [ACC_W-1:0] merge_half(
		input logic [ACC_W-1:0]                  cur,
		input logic [dds_ctrl_pkg::WORD_W-1:0]   w,
		input logic                              upper
	);
		logic [ACC_W-1:0] r;
		r = cur;
		if (upper)
			r[ACC_W-1:dds_ctrl_pkg::HALF_W] = w[dds_ctrl_pkg::HALF_W-1:0];
		else
			r[dds_ctrl_pkg::HALF_W-1:0] = w[dds_ctrl_pkg::HALF_W-1:0];
		return r;
	endfunction

	// ==========================================================
	// Serial link and crossing
	dds_serial_rx u_rx (
		.serial_clk     (serial_clk),
		.frame_sync_n   (frame_sync_n),
		.serial_data_in (serial_data_in),
		.word_q         (rx_word),
		.word_done_q    (rx_done)
	);

	// The done level crosses through two flops; its rise loads the word.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			done_s1_q   <= 1'b0;
			done_s2_q   <= 1'b0;
			done_prev_q <= 1'b0;
		end else begin
			done_s1_q   <= rx_done;
			done_s2_q   <= done_s1_q;
			done_prev_q <= done_s2_q;
		end
	end

	assign load = done_s2_q && !done_prev_q; // RULE_01

	// ==========================================================
	// Pin synchronisers
	always_comb begin
		pins_raw                          = '0;
		pins_raw[dds_ctrl_pkg::SYN_FREQ_WORD_SELECT_BIT]  = freq_word_select_pin;
		pins_raw[dds_ctrl_pkg::SYN_PSEL]  = phase_word_select_pin;
		pins_raw[dds_ctrl_pkg::SYN_RST]   = dds_reset;
		pins_raw[dds_ctrl_pkg::SYN_SLEEP] = dac_sleep_pin;
		pins_raw[dds_ctrl_pkg::SYN_COMP]  = comparator_input;
	end

	dds_bit_sync #(
		.W (dds_ctrl_pkg::SYNC_W)
	) u_sync (
		.clk      (clk),
		.nrst     (nrst),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	assign reset_s = pins_s[dds_ctrl_pkg::SYN_RST];
	assign sleep_s = pins_s[dds_ctrl_pkg::SYN_SLEEP];
	assign comp_s  = pins_s[dds_ctrl_pkg::SYN_COMP];

	// ==========================================================
	// Host written words; the reset input never touches them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctl_q <= dds_ctrl_pkg::CTL_RESET;
		end else if (load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
				== dds_ctrl_pkg::ADDR_CTRL) begin
			ctl_q <= rx_word[dds_ctrl_pkg::CTL_W-1:0]; // RULE_10
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			freq_word_a <= '0;
			freq_word_b <= '0;
		end else if (load) begin
			case (rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO])
				dds_ctrl_pkg::ADDR_FREQ_A: begin
					freq_word_a <= merge_half(freq_word_a, rx_word,
						freq_half_msb_bit);
				end
				dds_ctrl_pkg::ADDR_FREQ_B: begin
					freq_word_b <= merge_half(freq_word_b, rx_word,
						freq_half_msb_bit);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_offset_a <= '0;
			phase_offset_b <= '0;
		end else if (load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
				== dds_ctrl_pkg::ADDR_PHASE) begin
			if (rx_word[dds_ctrl_pkg::PHASE_SEL_POS])
				phase_offset_b <= rx_word[PHASE_W-1:0]; // RULE_16
			else
				phase_offset_a <= rx_word[PHASE_W-1:0]; // RULE_16
		end
	end

	assign freq_word_select_bit  = ctl_q[dds_ctrl_pkg::CTL_FREQ_WORD_SELECT_BIT_POS];
	assign phase_word_select_bit = ctl_q[dds_ctrl_pkg::CTL_PSEL_POS];
	assign pin_select_mode       = ctl_q[dds_ctrl_pkg::CTL_PINSEL_POS];
	assign dac_powerdown_bit     = ctl_q[dds_ctrl_pkg::CTL_SLEEP_POS];
	assign logic_out_enable_bit  = ctl_q[dds_ctrl_pkg::CTL_OEN_POS];
	assign logic_out_source_bit  = ctl_q[dds_ctrl_pkg::CTL_SRC_POS];
	assign freq_half_msb_bit     = ctl_q[dds_ctrl_pkg::CTL_HALF_POS];

	// ==========================================================
	// Word selection by pin or by control bit
	assign freq_pick  = pin_select_mode ? pins_s[dds_ctrl_pkg::SYN_FREQ_WORD_SELECT_BIT]
		: freq_word_select_bit; // RULE_06
	assign phase_pick = pin_select_mode ? pins_s[dds_ctrl_pkg::SYN_PSEL]
		: phase_word_select_bit; // RULE_08
	assign freq_sel   = freq_pick ? freq_word_b : freq_word_a; // RULE_05
	assign phase_sel  = phase_pick ? phase_offset_b : phase_offset_a; // RULE_07

	// ==========================================================
	// Oscillator and phase offset adder, on the master clock only
	always_ff @(posedge clk) begin
		if (!nrst || reset_s)
			accum_q <= '0; // RULE_09
		else
			accum_q <= accum_q + freq_sel; // RULE_04 RULE_15
	end

	always_ff @(posedge clk) begin
		if (!nrst || reset_s)
			phase_word_q <= '0; // RULE_09
		else
			phase_word_q <= accum_q[ACC_W-1 -: PHASE_W] + phase_sel; // RULE_16
	end

	// ==========================================================
	// DAC power down and sign output
	assign dac_powered_down = sleep_s || dac_powerdown_bit; // RULE_11

	assign comparator_connect = logic_out_enable_bit
		&& logic_out_source_bit; // RULE_14

	always_ff @(posedge clk) begin
		if (!nrst)
			sign_out_q <= 1'b0;
		else if (!logic_out_enable_bit)
			sign_out_q <= 1'b0;
		else if (logic_out_source_bit)
			sign_out_q <= comp_s; // RULE_13 RULE_14
		else
			sign_out_q <= accum_q[ACC_W-1]; // RULE_13 RULE_17
	end

	assign sign_out_oe_n = !logic_out_enable_bit; // RULE_12

	// ==========================================================
	// Assertions
	a_acc_step: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
		!reset_s |=> accum_q == ACC_W'($past(accum_q) + $past(freq_sel)))
		else $error("accumulator did not advance by the selected word");

	a_acc_clear: assert property (@(posedge clk) disable iff (!nrst) // RULE_09
		reset_s |=> accum_q == '0 && phase_word_q == '0)
		else $error("reset input did not clear the oscillator");

	a_regs_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
		reset_s && !load |=> $stable(freq_word_a) && $stable(freq_word_b)
			&& $stable(ctl_q) && $stable(phase_offset_a)
			&& $stable(phase_offset_b))
		else $error("reset input changed a host written word");

	a_freq_pick: assert property (@(posedge clk) disable iff (!nrst) // RULE_05
		pin_select_mode && pins_s[dds_ctrl_pkg::SYN_FREQ_WORD_SELECT_BIT]
			|-> freq_sel == freq_word_b)
		else $error("frequency pin did not select word b");

	a_phase_add: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
		!reset_s |=> phase_word_q == PHASE_W'($past(accum_q[ACC_W-1 -: PHASE_W])
			+ $past(phase_sel)))
		else $error("phase offset not added to accumulator top bits");

	a_sleep_dac: assert property (@(posedge clk) disable iff (!nrst) // RULE_11
		sleep_s || dac_powerdown_bit |-> dac_powered_down)
		else $error("DAC not powered down");

	a_sign_off: assert property (@(posedge clk) disable iff (!nrst) // RULE_12
		!logic_out_enable_bit |-> sign_out_oe_n ##1 !sign_out_q)
		else $error("sign output driven while disabled");

	a_sign_msb: assert property (@(posedge clk) disable iff (!nrst) // RULE_17
		logic_out_enable_bit && !logic_out_source_bit
			|=> sign_out_q == $past(accum_q[ACC_W-1]))
		else $error("sign output does not follow oscillator MSB");

	a_sign_comp: assert property (@(posedge clk) disable iff (!nrst) // RULE_14
		logic_out_enable_bit && logic_out_source_bit
			|-> comparator_connect ##1 sign_out_q == $past(comp_s))
		else $error("comparator not routed to sign output");

	a_load_once: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
		load |=> !load)
		else $error("one word loaded twice");

	// ==========================================================
	// Selection checks
	// The pins pick the words only while pin mode is on.
	a_phase_pin: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
		pin_select_mode && pins_s[dds_ctrl_pkg::SYN_PSEL]
			|-> phase_sel == phase_offset_b)
		else $error("phase pin did not select offset b");

	a_freq_pin_a: assert property (@(posedge clk) disable iff (!nrst) // RULE_05
		pin_select_mode && !pins_s[dds_ctrl_pkg::SYN_FREQ_WORD_SELECT_BIT]
			|-> freq_sel == freq_word_a)
		else $error("frequency pin did not select word a");

	a_freq_bit: assert property (@(posedge clk) disable iff (!nrst) // RULE_06
		!pin_select_mode |-> freq_sel == (freq_word_select_bit
			? freq_word_b : freq_word_a))
		else $error("frequency bit did not pick the word");

	a_phase_bit: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
		!pin_select_mode |-> phase_sel == (phase_word_select_bit
			? phase_offset_b : phase_offset_a))
		else $error("phase bit did not pick the offset");

	a_sleep_off: assert property (@(posedge clk) disable iff (!nrst) // RULE_11
		!sleep_s && !dac_powerdown_bit |-> !dac_powered_down)
		else $error("DAC powered down with no request");

	// ==========================================================
	// Register load checks
	a_ctl_load: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
		load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
			== dds_ctrl_pkg::ADDR_CTRL
			|=> ctl_q == $past(rx_word[dds_ctrl_pkg::CTL_W-1:0]))
		else $error("control word not loaded");

	// A frequency write fills only the half chosen by the half bit.
	a_freq_lo: assert property (@(posedge clk) disable iff (!nrst) // RULE_05
		load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
			== dds_ctrl_pkg::ADDR_FREQ_A && !freq_half_msb_bit
			|=> freq_word_a[dds_ctrl_pkg::HALF_W-1:0]
			== $past(rx_word[dds_ctrl_pkg::HALF_W-1:0]))
		else $error("low half of frequency word a not loaded");

	a_freq_hi: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
		load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
			== dds_ctrl_pkg::ADDR_FREQ_B && freq_half_msb_bit
			|=> freq_word_b[ACC_W-1:dds_ctrl_pkg::HALF_W]
			== $past(rx_word[dds_ctrl_pkg::HALF_W-1:0]))
		else $error("high half of frequency word b not loaded");

	a_phase_ldb: assert property (@(posedge clk) disable iff (!nrst) // RULE_16
		load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
			== dds_ctrl_pkg::ADDR_PHASE
			&& rx_word[dds_ctrl_pkg::PHASE_SEL_POS]
			|=> phase_offset_b == $past(rx_word[PHASE_W-1:0]))
		else $error("phase offset b not loaded");

	a_phase_lda: assert property (@(posedge clk) disable iff (!nrst) // RULE_16
		load && rx_word[dds_ctrl_pkg::ADDR_HI:dds_ctrl_pkg::ADDR_LO]
			== dds_ctrl_pkg::ADDR_PHASE
			&& !rx_word[dds_ctrl_pkg::PHASE_SEL_POS]
			|=> phase_offset_a == $past(rx_word[PHASE_W-1:0]))
		else $error("phase offset a not loaded");

endmodule
`default_nettype wire

// ==== testbench/host_link.sv ====
// Host model that writes framed serial words into the synthesizer.
`timescale 1ns/10ps
`default_nettype none
module host_link (
	output logic serial_clk,
	output logic frame_sync_n,
	output logic serial_data_in
);
	// ==========================================================
	// Idle levels
	// The frame rises just after time zero, so that the receiver sees a
	// rising edge that clears its count before the first word.
	initial begin
		serial_clk     = 1'b1;
		serial_data_in = 1'b0;
		#1;
		frame_sync_n   = 1'b1;
	end

	// ==========================================================
	// Framed transfer
	// Sends the top n bits of w, MSB first; n below 16 aborts the frame.
	// The serial clock stands high outside frames.
	task automatic send(input logic [16:0] w, input int n);
		frame_sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_data_in = w[16-i];
			#6 serial_clk = 1'b0;
			#6 serial_clk = 1'b1;
		end
		#6 frame_sync_n = 1'b1;
		serial_data_in = ~serial_data_in;
		#60;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench of the synthesizer pin control front end.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk;
	logic        nrst;
	logic        freq_word_select_bit_pin;
	logic        psel_pin;
	logic        dds_reset;
	logic        sleep_pin;
	logic        comp_in;
	wire         serial_clk;
	wire         frame_sync_n;
	wire         serial_data_in;
	logic [11:0] phase_word_q;
	logic [27:0] accum_q;
	logic        dpd;
	logic        conn;
	logic        sign_q;
	logic        oe_n;
	logic [27:0] obs [6];
	logic [27:0] v;
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	typedef struct {int s; logic [27:0] e;} note_t;
	note_t       notes[$];
	note_t       cur;
	event        chk_ev;
	string       nm [6] = '{"accum", "phase", "sleep", "connect", "sign", "oe_n"};

	host_link i_host (
		.serial_clk     (serial_clk),
		.frame_sync_n   (frame_sync_n),
		.serial_data_in (serial_data_in)
	);

	dds_pin_ctrl i_dut (
		.clk                   (clk),
		.nrst                  (nrst),
		.serial_clk            (serial_clk),
		.frame_sync_n          (frame_sync_n),
		.serial_data_in        (serial_data_in),
		.freq_word_select_pin  (freq_word_select_bit_pin),
		.phase_word_select_pin (psel_pin),
		.dds_reset             (dds_reset),
		.dac_sleep_pin         (sleep_pin),
		.comparator_input      (comp_in),
		.phase_word_q          (phase_word_q),
		.accum_q               (accum_q),
		.dac_powered_down      (dpd),
		.comparator_connect    (conn),
		.sign_out_q            (sign_q),
		.sign_out_oe_n         (oe_n)
	);

	// ==========================================================
	// Clock, timeout and result checker
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			end_of_test;
		end
	end

	always_comb begin
		obs[0] = accum_q;
		obs[1] = {16'h0000, phase_word_q};
		obs[2] = {27'h0000000, dpd};
		obs[3] = {27'h0000000, conn};
		obs[4] = {27'h0000000, sign_q};
		obs[5] = {27'h0000000, oe_n};
	end

	always @(chk_ev) begin
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			v = obs[cur.s];
			comparisons++;
			if (v !== cur.e) begin
				$display("[ERR] %s expected %h seen %h", nm[cur.s], cur.e, v);
				err_count++;
			end
		end
	end

	// ==========================================================
	// Tasks
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic note(input int s, input logic [27:0] e);
		notes.push_back('{s, e});
		->chk_ev;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [1:0] a, input logic [13:0] d);
		i_host.send({a, d, 1'b0}, 16);
		tick(8);
	endtask

	// Accumulator must advance by exactly ten times f over ten clocks.
	task automatic rate(input logic [27:0] f);
		logic [27:0] a0;
		tick(4);
		a0 = accum_q;
		tick(10);
		note(0, a0 + f * 28'h000000A);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [13:0] fa;
		logic [13:0] fb;
		logic [11:0] pa;
		logic [11:0] pb;
		logic        b;
		logic        r;
		nrst = 1'b0;
		freq_word_select_bit_pin = 1'b0;
		psel_pin = 1'b0;
		dds_reset = 1'b0;
		sleep_pin = 1'b0;
		comp_in = 1'b0;
		void'($urandom(32'h4990B88B));
		fa = 14'($urandom);
		fb = 14'($urandom);
		pa = 12'($urandom);
		pb = 12'($urandom);
		tick(16);
		nrst = 1'b1;
		tick(4);
		wr(dds_ctrl_pkg::ADDR_FREQ_A, fa);
		wr(dds_ctrl_pkg::ADDR_FREQ_B, fb);
		for (int i = 0; i < 4; i++) begin
			b = i[0] ^ i[1];
			freq_word_select_bit_pin = ~b;
			wr(dds_ctrl_pkg::ADDR_CTRL, {11'h000, i[1], 1'b0, b});
			rate(i[0] ? {14'h0000, fb} : {14'h0000, fa});
		end
		freq_word_select_bit_pin = 1'b0;
		dds_reset = 1'b1;
		tick(4);
		note(0, 28'h0000000);
		note(1, 28'h0000000);
		dds_reset = 1'b0;
		rate({14'h0000, fa});
		wr(dds_ctrl_pkg::ADDR_FREQ_A, 14'h0000);
		dds_reset = 1'b1;
		tick(4);
		dds_reset = 1'b0;
		wr(dds_ctrl_pkg::ADDR_PHASE, {2'b00, pa});
		wr(dds_ctrl_pkg::ADDR_PHASE, {2'b10, pb});
		for (int i = 0; i < 4; i++) begin
			b = i[0] ^ i[1];
			psel_pin = ~b;
			wr(dds_ctrl_pkg::ADDR_CTRL, {11'h000, i[1], b, 1'b0});
			note(1, {16'h0000, i[0] ? pb : pa});
		end
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0000);
		i_host.send({dds_ctrl_pkg::ADDR_FREQ_A, 14'h3FFF, 1'b0}, 9);
		rate(28'h0000000);
		i_host.send({dds_ctrl_pkg::ADDR_FREQ_A, fb, 1'b1}, 17);
		rate({14'h0000, fb});
		sleep_pin = 1'b1;
		tick(4);
		note(2, 28'h0000001);
		sleep_pin = 1'b0;
		tick(4);
		note(2, 28'h0000000);
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0008);
		note(2, 28'h0000001);
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0000);
		note(5, 28'h0000001);
		note(4, 28'h0000000);
		note(3, 28'h0000000);
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0030);
		note(5, 28'h0000000);
		note(3, 28'h0000001);
		repeat (4) begin
			r = 1'($urandom);
			comp_in = r;
			tick(4);
			note(4, {27'h0000000, r});
		end
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0040);
		wr(dds_ctrl_pkg::ADDR_FREQ_A, 14'h2000);
		wr(dds_ctrl_pkg::ADDR_CTRL, 14'h0010);
		repeat (4) begin
			r = accum_q[27];
			tick(1);
			note(4, {27'h0000000, r});
		end
		tick(1);
		end_of_test;
	end
endmodule
`default_nettype wire
